// ==== logic/ppbt_dev.sv ====
`timescale 1ns/10ps
// Summary of operation
// - framebuffer pixel, aux data delayed five stages
// - window id and cursor delayed seven stages
// - option video arrives on two quarter-rate channels
// - incoming channel 0 takes six stages
// - incoming channel 1 takes seven stages
// - board sends channel 1 one cycle early
// - returned colour to channel 0 after six
// - returned colour to channel 1 after five
// - no mode RAM writes during visible pixels
// - blank rises thirteen cycles before DAC blank
// - quarter-rate phase follows blank rising edge
// - blank rise aligned to quarter-rate clock edge
// - blank rises fourteen cycles before video needed
// - dither x resets and dither y steps on blank rise
// - blank rise offset identical every line
// - blank falls no earlier than ten before
// - long blanking preferred for write bandwidth
// - queue drains into RAM only while blanking
// - queue entry is address plus mode word
module ppbt_dev (
    // link to the far end
    ppbt_if.dev lnk,
    // user side: mode RAM readback, quarter-rate phase and dither position
    input wire logic [ppbt_pkg::MADDR_W-1:0] mode_rd_addr,
    output logic [ppbt_pkg::MWORD_W-1:0] mode_rd_data,
    output logic phase_ff,
    output logic [ppbt_pkg::DITHER_W-1:0] dith_x_ff,
    output logic [ppbt_pkg::DITHER_W-1:0] dith_y_ff
);
    localparam int FBW = ppbt_pkg::PIX_W + ppbt_pkg::AUX_W;
    localparam int VCW = ppbt_pkg::DID_W + ppbt_pkg::CUR_W;
    localparam int VW = ppbt_pkg::VID_W;

    // ************************************************************
    // generic delay line
    // ************************************************************
    logic [FBW-1:0] fb_ff [ppbt_pkg::FB_STAGES];
    logic [VCW-1:0] vc_ff [ppbt_pkg::VC_STAGES];
    logic [VW-1:0] vi0_ff [ppbt_pkg::VIN0_STAGES];
    logic [VW-1:0] vi1_ff [ppbt_pkg::VIN1_STAGES];
    logic [VW-1:0] vo0_ff [ppbt_pkg::VOUT0_STAGES];
    logic [VW-1:0] vo1_ff [ppbt_pkg::VOUT1_STAGES];

    // stage zero loads
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
            fb_ff[0] <= '0;
            vc_ff[0] <= '0;
            vi0_ff[0] <= '0;
            vi1_ff[0] <= '0;
            vo0_ff[0] <= '0;
            vo1_ff[0] <= '0;
        end else begin
            fb_ff[0] <= {lnk.fb_pix, lnk.fb_aux};
            vc_ff[0] <= {lnk.vc_did, lnk.vc_cur};
            vi0_ff[0] <= lnk.vin_ch0;
            vi1_ff[0] <= lnk.vin_ch1;
            vo0_ff[0] <= lnk.cm_ret;
            vo1_ff[0] <= lnk.cm_ret;
        end
    end

    // remaining stages of each line
    genvar g;
    generate
        // framebuffer pixel and aux stages
        for (g = 1; g < ppbt_pkg::FB_STAGES; g++) begin : g_fb
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    fb_ff[g] <= '0;
                end else begin
                    fb_ff[g] <= fb_ff[g-1];
                end
            end
        end
        // window id and cursor stages
        for (g = 1; g < ppbt_pkg::VC_STAGES; g++) begin : g_vc
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    vc_ff[g] <= '0;
                end else begin
                    vc_ff[g] <= vc_ff[g-1];
                end
            end
        end
        // incoming video channel 0 stages
        for (g = 1; g < ppbt_pkg::VIN0_STAGES; g++) begin : g_vi0
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    vi0_ff[g] <= '0;
                end else begin
                    vi0_ff[g] <= vi0_ff[g-1];
                end
            end
        end
        // incoming video channel 1 stages, one longer
        for (g = 1; g < ppbt_pkg::VIN1_STAGES; g++) begin : g_vi1
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    vi1_ff[g] <= '0;
                end else begin
                    vi1_ff[g] <= vi1_ff[g-1];
                end
            end
        end
        // returned colour to channel 0
        for (g = 1; g < ppbt_pkg::VOUT0_STAGES; g++) begin : g_vo0
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    vo0_ff[g] <= '0;
                end else begin
                    vo0_ff[g] <= vo0_ff[g-1];
                end
            end
        end
        // returned colour to channel 1, one shorter
        for (g = 1; g < ppbt_pkg::VOUT1_STAGES; g++) begin : g_vo1
            always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
                if (!lnk.rstn) begin
                    vo1_ff[g] <= '0;
                end else begin
                    vo1_ff[g] <= vo1_ff[g-1];
                end
            end
        end
    endgenerate

    // ************************************************************
    // outputs from final stages
    // ************************************************************
    assign {lnk.cm_pix, lnk.cm_aux} = fb_ff[ppbt_pkg::FB_STAGES-1];
    assign {lnk.cm_did, lnk.cm_cur} = vc_ff[ppbt_pkg::VC_STAGES-1];
    assign lnk.cm_vid0 = vi0_ff[ppbt_pkg::VIN0_STAGES-1];
    assign lnk.cm_vid1 = vi1_ff[ppbt_pkg::VIN1_STAGES-1];
    assign lnk.vout_ch0 = vo0_ff[ppbt_pkg::VOUT0_STAGES-1];
    assign lnk.vout_ch1 = vo1_ff[ppbt_pkg::VOUT1_STAGES-1];

    // ************************************************************
    // blank edge, quarter-rate phase, dither
    // ************************************************************
    logic blank_d_ff;
    logic blank_rise;
    assign blank_rise = lnk.blank_n && !blank_d_ff;

    // previous blank level
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) blank_d_ff <= 1'b0;
        else blank_d_ff <= lnk.blank_n;
    end

    // quarter-rate phase, high in the cycle after a blank rise
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) phase_ff <= 1'b0;
        else if (blank_rise) phase_ff <= 1'b1;
        else phase_ff <= !phase_ff;
    end

    // dither position: x steps in active time, y steps per line
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) begin
            dith_x_ff <= '0;
            dith_y_ff <= '0;
        end else if (blank_rise) begin
            dith_x_ff <= '0;
            dith_y_ff <= dith_y_ff + 1'b1;
        end else if (lnk.blank_n) begin
            dith_x_ff <= dith_x_ff + 1'b1;
        end
    end

    // ************************************************************
    // mode register queue and RAM
    // ************************************************************
    logic q_valid;
    logic [ppbt_pkg::MENTRY_W-1:0] q_data;
    logic q_pop;
    logic [ppbt_pkg::MWORD_W-1:0] mram [ppbt_pkg::MRAM_DEPTH];

    // drain only during blanking (low level)
    assign q_pop = !lnk.blank_n;

    ppbt_fifo #(
        .WIDTH(ppbt_pkg::MENTRY_W),
        .DEPTH(ppbt_pkg::FIFO_DEPTH)
    ) u_mq (
        .clock(lnk.clock),
        .rstn(lnk.rstn),
        .in_valid(lnk.mq_valid),
        .in_ready(lnk.mq_ready),
        .in_data(lnk.mq_data),
        .out_valid(q_valid),
        .out_ready(q_pop),
        .out_data(q_data)
    );

    // RAM write: address in top five bits, word below
    always_ff @(posedge lnk.clock) begin
        if (q_valid && q_pop) begin
            mram[q_data[ppbt_pkg::MENTRY_W-1 -: ppbt_pkg::MADDR_W]] <=
                q_data[ppbt_pkg::MWORD_W-1:0];
        end
    end

    // registered readback
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) mode_rd_data <= '0;
        else mode_rd_data <= mram[mode_rd_addr];
    end
endmodule : ppbt_dev

// ==== shared/ppbt_pkg.sv ====
package ppbt_pkg;
    // ************************************************************
    // widths and depths
    // ************************************************************
    localparam int PIX_W = 24;
    localparam int AUX_W = 10;
    localparam int DID_W = 5;
    localparam int CUR_W = 2;
    localparam int VID_W = 24;
    localparam int MADDR_W = 5;
    localparam int MWORD_W = 24;
    localparam int MENTRY_W = 29;
    localparam int MRAM_DEPTH = 32;
    localparam int FIFO_DEPTH = 8;
    // ************************************************************
    // pipeline stage counts
    // ************************************************************
    localparam int FB_STAGES = 5;
    localparam int VC_STAGES = 7;
    localparam int VIN0_STAGES = 6;
    localparam int VIN1_STAGES = 7;
    localparam int VOUT0_STAGES = 6;
    localparam int VOUT1_STAGES = 5;
    // ************************************************************
    // blank timing figures, in half-rate cycles; dither width
    // ************************************************************
    localparam int BLANK_RISE_LEAD = 13;
    localparam int BLANK_VIDEO_LEAD = 14;
    localparam int BLANK_FALL_LEAD = 10;
    localparam int DITHER_W = 2;
    // ************************************************************
    // host-end sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        PPBT_ACTIVE = 2'h0,
        PPBT_FALL = 2'h1,
        PPBT_BLANK = 2'h3,
        PPBT_RISE = 2'h2
    } ppbt_seq_type;
endpackage : ppbt_pkg

// ==== shared/ppbt_if.sv ====
`timescale 1ns/10ps
interface ppbt_if (
    input wire logic clock,
    input wire logic rstn
);
    // framebuffer and controller data
    logic [ppbt_pkg::PIX_W-1:0] fb_pix;
    logic [ppbt_pkg::AUX_W-1:0] fb_aux;
    logic [ppbt_pkg::DID_W-1:0] vc_did;
    logic [ppbt_pkg::CUR_W-1:0] vc_cur;
    logic blank_n;
    // option board video
    logic [ppbt_pkg::VID_W-1:0] vin_ch0;
    logic [ppbt_pkg::VID_W-1:0] vin_ch1;
    logic [ppbt_pkg::VID_W-1:0] vout_ch0;
    logic [ppbt_pkg::VID_W-1:0] vout_ch1;
    // colour map
    logic [ppbt_pkg::PIX_W-1:0] cm_pix;
    logic [ppbt_pkg::AUX_W-1:0] cm_aux;
    logic [ppbt_pkg::DID_W-1:0] cm_did;
    logic [ppbt_pkg::CUR_W-1:0] cm_cur;
    logic [ppbt_pkg::VID_W-1:0] cm_vid0;
    logic [ppbt_pkg::VID_W-1:0] cm_vid1;
    logic [ppbt_pkg::PIX_W-1:0] cm_ret;
    // mode register queue
    logic mq_valid;
    logic mq_ready;
    logic [ppbt_pkg::MENTRY_W-1:0] mq_data;

    modport dev (
        input clock, rstn, fb_pix, fb_aux, vc_did, vc_cur, blank_n,
        input vin_ch0, vin_ch1, cm_ret, mq_valid, mq_data,
        output vout_ch0, vout_ch1, cm_pix, cm_aux, cm_did, cm_cur,
        output cm_vid0, cm_vid1, mq_ready
    );
    modport host (
        input clock, rstn, vout_ch0, vout_ch1, cm_pix, cm_aux, cm_did,
        input cm_cur, cm_vid0, cm_vid1, mq_ready,
        output fb_pix, fb_aux, vc_did, vc_cur, blank_n, vin_ch0, vin_ch1,
        output cm_ret, mq_valid, mq_data
    );
endinterface : ppbt_if

// ==== logic/ppbt_fifo.sv ====
`timescale 1ns/10ps
module ppbt_fifo #(
    parameter int WIDTH = 29,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic [AW:0] nxt_cnt;
    logic push;
    logic pop;

    // handshake terms
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem[rd_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

    // storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wr_ff] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            in_ready <= 1'b1;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= nxt_cnt;
            // ready held in a flop so the pin leaves the block registered
            in_ready <= (nxt_cnt != (AW+1)'(DEPTH));
        end
    end
endmodule : ppbt_fifo

// ==== logic/ppbt_host.sv ====
`timescale 1ns/10ps
module ppbt_host (
    // link to the device
    ppbt_if.host lnk,
    // user side: data to send
    input wire logic [ppbt_pkg::PIX_W-1:0] u_pix,
    input wire logic [ppbt_pkg::AUX_W-1:0] u_aux,
    input wire logic [ppbt_pkg::DID_W-1:0] u_did,
    input wire logic [ppbt_pkg::CUR_W-1:0] u_cur,
    input wire logic [ppbt_pkg::VID_W-1:0] u_vid0,
    input wire logic [ppbt_pkg::VID_W-1:0] u_vid1,
    input wire logic [ppbt_pkg::PIX_W-1:0] u_ret,
    // user side: blank request and mode writes
    input wire logic u_blank_n,
    input wire logic u_mq_valid,
    input wire logic [ppbt_pkg::MENTRY_W-1:0] u_mq_data,
    output logic u_mq_ready_ff
);
    logic ph_ff;
    logic [ppbt_pkg::VID_W-1:0] vid1_hold_ff;
    logic blank_ff;

    // quarter-rate phase: blank may rise only when phase is high
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) ph_ff <= 1'b0;
        else ph_ff <= !ph_ff;
    end

    // blank rise held to a quarter-rate edge, fall any time
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) blank_ff <= 1'b0;
        else if (!u_blank_n) blank_ff <= 1'b0;
        else if (ph_ff) blank_ff <= 1'b1;
    end

    // channel 1 leads channel 0 by one cycle
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) vid1_hold_ff <= '0;
        else vid1_hold_ff <= u_vid0;
    end

    // ready echo for the user
    always_ff @(posedge lnk.clock or negedge lnk.rstn) begin
        if (!lnk.rstn) u_mq_ready_ff <= 1'b0;
        else u_mq_ready_ff <= lnk.mq_ready;
    end

    // link drives: pass-through, except blank_n from blank_ff and vin_ch0 from vid1_hold_ff
    assign lnk.blank_n = blank_ff;
    assign lnk.fb_pix = u_pix;
    assign lnk.fb_aux = u_aux;
    assign lnk.vc_did = u_did;
    assign lnk.vc_cur = u_cur;
    assign lnk.vin_ch0 = vid1_hold_ff;
    assign lnk.vin_ch1 = u_vid1;
    assign lnk.cm_ret = u_ret;
    assign lnk.mq_valid = u_mq_valid;
    assign lnk.mq_data = u_mq_data;
endmodule : ppbt_host

// ==== tb/ppbt_properties.sv ====
`timescale 1ns/10ps
module ppbt_properties (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // host driven
    input wire logic [ppbt_pkg::PIX_W-1:0] fb_pix,
    input wire logic [ppbt_pkg::AUX_W-1:0] fb_aux,
    input wire logic [ppbt_pkg::DID_W-1:0] vc_did,
    input wire logic [ppbt_pkg::CUR_W-1:0] vc_cur,
    input wire logic blank_n,
    input wire logic [ppbt_pkg::VID_W-1:0] vin_ch0,
    input wire logic [ppbt_pkg::VID_W-1:0] vin_ch1,
    input wire logic [ppbt_pkg::PIX_W-1:0] cm_ret,
    input wire logic mq_valid,
    // device driven
    input wire logic [ppbt_pkg::PIX_W-1:0] cm_pix,
    input wire logic [ppbt_pkg::AUX_W-1:0] cm_aux,
    input wire logic [ppbt_pkg::DID_W-1:0] cm_did,
    input wire logic [ppbt_pkg::CUR_W-1:0] cm_cur,
    input wire logic [ppbt_pkg::VID_W-1:0] cm_vid0,
    input wire logic [ppbt_pkg::VID_W-1:0] cm_vid1,
    input wire logic [ppbt_pkg::VID_W-1:0] vout_ch0,
    input wire logic [ppbt_pkg::VID_W-1:0] vout_ch1,
    input wire logic mq_ready
);
    logic [3:0] run_ff;
    logic [3:0] nxt_run;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ************************************************************
    // cycles since reset, so history never reaches into reset
    // ************************************************************
    assign nxt_run = (run_ff == 4'hF) ? run_ff : run_ff + 4'h1;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 4'h0;
        end else begin
            run_ff <= nxt_run;
        end
    end
    // ************************************************************
    // pipeline depths and queue gating
    // ************************************************************
    fb_delay_a:
    assert property (run_ff >= 4'h8 |-> cm_pix == $past(fb_pix, 5) && cm_aux == $past(fb_aux, 5))
        else $error("frame data delay wrong");
    vc_delay_a:
    assert property (run_ff >= 4'h8 |-> cm_did == $past(vc_did, 7) && cm_cur == $past(vc_cur, 7))
        else $error("id and cursor delay wrong");
    vin0_delay_a:
    assert property (run_ff >= 4'h8 |-> cm_vid0 == $past(vin_ch0, 6))
        else $error("video channel 0 delay wrong");
    vin1_delay_a:
    assert property (run_ff >= 4'h8 |-> cm_vid1 == $past(vin_ch1, 7))
        else $error("video channel 1 delay wrong");
    vout0_delay_a:
    assert property (run_ff >= 4'h8 |-> vout_ch0 == $past(cm_ret, 6))
        else $error("return channel 0 delay wrong");
    vout1_delay_a:
    assert property (run_ff >= 4'h8 |-> vout_ch1 == $past(cm_ret, 5))
        else $error("return channel 1 delay wrong");
    active_no_drain_a:
    assert property (blank_n |=> !$rose(mq_ready))
        else $error("queue drained during active video");
    blank_drain_a:
    assert property (!blank_n && !mq_ready |=> mq_ready)
        else $error("full queue not drained in blanking");
    // main scenarios
    cover property (!blank_n && !mq_ready ##1 mq_ready);
    cover property ($rose(blank_n));
    cover property (blank_n && mq_valid && !mq_ready);
endmodule : ppbt_properties

// ==== tb/ppbt_tb_top.sv ====
`timescale 1ns/10ps
module ppbt_tb_top;
    localparam int PW = ppbt_pkg::PIX_W;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    int errors = 0;
    int tests_run = 0;
    logic [PW-1:0] u_pix = '0;
    logic [ppbt_pkg::AUX_W-1:0] u_aux = '0;
    logic [ppbt_pkg::DID_W-1:0] u_did = '0;
    logic [ppbt_pkg::CUR_W-1:0] u_cur = '0;
    logic [PW-1:0] u_vid0 = '0;
    logic [PW-1:0] u_vid1 = '0;
    logic [PW-1:0] u_ret = '0;
    logic u_blank_n = 1'b0;
    logic u_mq_valid = 1'b0;
    logic [ppbt_pkg::MENTRY_W-1:0] u_mq_data = '0;
    logic u_mq_ready_ff;
    logic [ppbt_pkg::MADDR_W-1:0] mode_rd_addr = '0;
    logic [ppbt_pkg::MWORD_W-1:0] mode_rd_data;
    logic phase_ff;
    logic [1:0] dith_x_ff;
    logic [1:0] dith_y_ff;
    // ************************************************************
    // clock, link and both ends
    // ************************************************************
    always #5 clock = ~clock;
    ppbt_if i_ppbt_if (.clock(clock), .rstn(rstn));
    ppbt_dev i_ppbt_dev (.lnk(i_ppbt_if), .mode_rd_addr(mode_rd_addr),
        .mode_rd_data(mode_rd_data), .phase_ff(phase_ff), .dith_x_ff(dith_x_ff),
        .dith_y_ff(dith_y_ff));
    ppbt_host i_ppbt_host (.lnk(i_ppbt_if), .u_pix(u_pix), .u_aux(u_aux), .u_did(u_did),
        .u_cur(u_cur), .u_vid0(u_vid0), .u_vid1(u_vid1), .u_ret(u_ret),
        .u_blank_n(u_blank_n), .u_mq_valid(u_mq_valid), .u_mq_data(u_mq_data),
        .u_mq_ready_ff(u_mq_ready_ff));
    ppbt_properties i_ppbt_properties (.clock(clock), .rstn(rstn),
        .fb_pix(i_ppbt_if.fb_pix), .fb_aux(i_ppbt_if.fb_aux), .vc_did(i_ppbt_if.vc_did),
        .vc_cur(i_ppbt_if.vc_cur), .blank_n(i_ppbt_if.blank_n),
        .vin_ch0(i_ppbt_if.vin_ch0), .vin_ch1(i_ppbt_if.vin_ch1),
        .cm_ret(i_ppbt_if.cm_ret), .mq_valid(i_ppbt_if.mq_valid),
        .cm_pix(i_ppbt_if.cm_pix), .cm_aux(i_ppbt_if.cm_aux), .cm_did(i_ppbt_if.cm_did),
        .cm_cur(i_ppbt_if.cm_cur), .cm_vid0(i_ppbt_if.cm_vid0),
        .cm_vid1(i_ppbt_if.cm_vid1), .vout_ch0(i_ppbt_if.vout_ch0),
        .vout_ch1(i_ppbt_if.vout_ch1), .mq_ready(i_ppbt_if.mq_ready));
    // ************************************************************
    // compare, pattern and verdict
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    function automatic logic [31:0] pat(input int k, input int s, input int w);
        logic [31:0] h;
        h = 32'h9E3779B1 * (k + 7) + 32'h01010101 * s;
        return h & ((32'h1 << w) - 32'h1);
    endfunction : pat
    task automatic finish_test();
        if (errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    // ************************************************************
    // access tasks
    // ************************************************************
    // new value every cycle on all streams, outputs checked against history
    task automatic run_pipes();
        for (int j = 0; j < 24; j++) begin
            @(negedge clock);
            if (j >= 8) begin
                check(i_ppbt_if.cm_pix, pat(j - 5, 1, PW));
                check(i_ppbt_if.cm_aux, pat(j - 5, 2, ppbt_pkg::AUX_W));
                check(i_ppbt_if.cm_did, pat(j - 7, 3, ppbt_pkg::DID_W));
                check(i_ppbt_if.cm_cur, pat(j - 7, 4, ppbt_pkg::CUR_W));
                check(i_ppbt_if.vin_ch0, pat(j - 1, 5, PW));
                check(i_ppbt_if.cm_vid0, pat(j - 7, 5, PW));
                check(i_ppbt_if.cm_vid1, pat(j - 7, 6, PW));
                check(i_ppbt_if.vout_ch0, pat(j - 6, 7, PW));
                check(i_ppbt_if.vout_ch1, pat(j - 5, 7, PW));
            end
            u_pix = PW'(pat(j, 1, PW));
            u_aux = ppbt_pkg::AUX_W'(pat(j, 2, ppbt_pkg::AUX_W));
            u_did = ppbt_pkg::DID_W'(pat(j, 3, ppbt_pkg::DID_W));
            u_cur = ppbt_pkg::CUR_W'(pat(j, 4, ppbt_pkg::CUR_W));
            u_vid0 = PW'(pat(j, 5, PW));
            u_vid1 = PW'(pat(j, 6, PW));
            u_ret = PW'(pat(j, 7, PW));
        end
    endtask : run_pipes
    task automatic set_blank(input logic v);
        @(negedge clock);
        u_blank_n = v;
        for (int n = 0; n < 6 && i_ppbt_if.blank_n !== v; n++) @(negedge clock);
        check(i_ppbt_if.blank_n, v);
    endtask : set_blank
    // end of blanking, then phase and dither walk
    task automatic line_start();
        logic [1:0] y0;
        y0 = dith_y_ff;
        set_blank(1'b1);
        for (int c = 0; c < 4; c++) begin
            @(negedge clock);
            check(phase_ff, 32'(c % 2 == 0));
            check(dith_x_ff, 32'(c));
        end
        check(dith_y_ff, 32'(2'(y0 + 2'h1)));
    endtask : line_start
    // called at a falling edge; valid stays up for back to back use
    task automatic mq_push(input logic [4:0] a, input logic [23:0] w);
        u_mq_valid = 1'b1;
        u_mq_data = {a, w};
        for (int n = 0; n < 20 && i_ppbt_if.mq_ready !== 1'b1; n++) @(negedge clock);
        check(i_ppbt_if.mq_ready, 1'b1);
        @(negedge clock);
    endtask : mq_push
    task automatic rd_check(input logic [4:0] a, input logic [23:0] w);
        mode_rd_addr = a;
        @(negedge clock);
        check(mode_rd_data, w);
    endtask : rd_check
    // ************************************************************
    // test sequence
    // ************************************************************
    initial begin
        repeat (20) @(negedge clock);
        rstn = 1'b1;
        @(negedge clock);
        run_pipes();
        for (int k = 0; k < 8; k++) mq_push(5'(k * 4 + 3), 24'hC30000 | 24'(k));
        u_mq_valid = 1'b0;
        repeat (4) @(negedge clock);
        for (int k = 0; k < 8; k++) rd_check(5'(k * 4 + 3), 24'hC30000 | 24'(k));
        line_start();
        for (int k = 0; k < 8; k++) mq_push(5'(k * 4 + 3), 24'h3C0F00 | 24'(k));
        u_mq_valid = 1'b0;
        check(i_ppbt_if.mq_ready, 1'b0);
        @(negedge clock);
        check(u_mq_ready_ff, 1'b0);
        repeat (6) @(negedge clock);
        for (int k = 0; k < 8; k++) rd_check(5'(k * 4 + 3), 24'hC30000 | 24'(k));
        set_blank(1'b0);
        repeat (12) @(negedge clock);
        for (int k = 0; k < 8; k++) rd_check(5'(k * 4 + 3), 24'h3C0F00 | 24'(k));
        check(i_ppbt_if.mq_ready, 1'b1);
        line_start();
        finish_test();
    end
    // watchdog: the run needs well under a thousand cycles
    initial begin
        #50000;
        errors++;
        finish_test();
    end
endmodule : ppbt_tb_top
